// ==== hdl/mic_regs.sv ====
// MAC interface configuration register block with AXI4-Lite slave
`timescale 1ns/1ns
module mic_regs
  import mic_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // AXI4-Lite write address, data and response
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Strap pins
  input  wire logic              rgmii_strap,
  input  wire logic              reference_frequency_strap,
  // Link clock pin and receive-path events
  input  wire logic              link_clk,
  input  wire logic              carrier_sense,
  input  wire logic              rx_data_pending,
  input  wire logic              rmii_recovered_mode,
  input  wire logic              fifo_overflow_evt,
  input  wire logic              fifo_underflow_evt,
  // Configuration outputs
  output      mic_mode_e         mac_mode,
  output      logic              rx_clk_delay_en,
  output      logic              tx_clk_delay_en,
  output      logic              tx_clk_synced,
  output      logic              rmii_tx_shift_en,
  output      logic              ref_clk_50m_sel,
  output      logic              rx_fifo_bypass,
  output      logic              rx_clk_50m_out_en,
  output      logic [3:0]        eb_tolerance_bits,
  output      logic              crs_dv,
  // Interrupt
  output      logic              irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[11:2];
  endfunction

  function automatic logic [3:0] eb_tol(input logic [1:0] code);
    unique case (code)
      2'h0: eb_tol = MIC_EB_TOL_00;
      2'h1: eb_tol = MIC_EB_TOL_01;
      2'h2: eb_tol = MIC_EB_TOL_10;
      2'h3: eb_tol = MIC_EB_TOL_11;
    endcase
  endfunction

  logic [15:0]       ctrl_q;
  logic              ovf_q;
  logic              unf_q;
  logic [1:0]        irq_stat_q;
  logic [1:0]        irq_mask_q;
  logic              aw_held_q;
  logic              w_held_q;
  logic [9:0]        aw_idx_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic [2:0]        lclk_q;
  logic [2:0]        rg_strap_q;
  logic [2:0]        ref_strap_q;
  logic [1:0]        strap_cnt_q;
  logic              strap_done_q;
  logic              crs_dv_q;
  logic              do_write;
  logic              ar_fire;
  logic              ctrl_read;
  logic              link_edge;
  logic [15:0]       ctrl_view;
  logic [15:0]       wmask;

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign do_write      = aw_held_q && w_held_q && !bvalid_q;
  assign ar_fire       = s_axi_arvalid && !rvalid_q;
  assign ctrl_read     = ar_fire && (word_idx(s_axi_araddr) == MIC_CTRL_IDX);
  assign wmask         = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}} & MIC_CTRL_RW_MASK;

  // Address and data are parked independently; the write lands once both are held
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_idx_q  <= 10'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= word_idx(s_axi_awaddr);
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= MIC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (aw_idx_q == MIC_CTRL_IDX || aw_idx_q == MIC_IRQ_STAT_IDX ||
                   aw_idx_q == MIC_IRQ_MASK_IDX) ? MIC_RESP_OKAY : MIC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // [RQ15] reserved bits zero
  assign ctrl_view = (ctrl_q & MIC_CTRL_RW_MASK) |
                     (16'h0001 << MIC_B_OVF) & {16{ovf_q}} |
                     (16'h0001 << MIC_B_UNF) & {16{unf_q}};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= MIC_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= MIC_RESP_OKAY;
      unique case (word_idx(s_axi_araddr))
        MIC_CTRL_IDX:     rdata_q <= {16'h0000, ctrl_view};
        MIC_IRQ_STAT_IDX: rdata_q <= {30'h0000_0000, irq_stat_q};
        MIC_IRQ_MASK_IDX: rdata_q <= {30'h0000_0000, irq_mask_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= MIC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rg_strap_q  <= 3'h0;
      ref_strap_q <= 3'h0;
      lclk_q      <= 3'h0;
    end else begin
      rg_strap_q  <= {rg_strap_q[1:0], rgmii_strap};
      ref_strap_q <= {ref_strap_q[1:0], reference_frequency_strap};
      lclk_q      <= {lclk_q[1:0], link_clk};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_cnt_q  <= strap_cnt_q + 2'h1;
      strap_done_q <= (strap_cnt_q == MIC_STRAP_WAIT);
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Strap load happens once, before software could plausibly write
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= MIC_CTRL_RST;
    end else if (!strap_done_q && strap_cnt_q == MIC_STRAP_WAIT) begin
      // [RQ4] strap sets RGMII
      ctrl_q[MIC_B_RGMII]   <= rg_strap_q[2];
      // [RQ7] strap sets reference
      ctrl_q[MIC_B_REF_SEL] <= ref_strap_q[2];
    end else if (do_write && aw_idx_q == MIC_CTRL_IDX) begin
      // [RQ15] writes to reserved ignored
      ctrl_q <= (ctrl_q & ~wmask) | (wdata_q[15:0] & wmask);
    end
  end

  // [RQ11] overflow flag, set wins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ovf_q <= 1'b0;
    end else if (fifo_overflow_evt) begin
      ovf_q <= 1'b1;
    end else if (ctrl_read) begin
      ovf_q <= 1'b0;
    end
  end

  // [RQ12] underflow flag, set wins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      unf_q <= 1'b0;
    end else if (fifo_underflow_evt) begin
      unf_q <= 1'b1;
    end else if (ctrl_read) begin
      unf_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
    end else begin
      if (do_write && aw_idx_q == MIC_IRQ_MASK_IDX && wstrb_q[0]) begin
        irq_mask_q <= wdata_q[1:0];
      end
      // Write-one-to-clear, a new event in the same cycle survives
      irq_stat_q <= (irq_stat_q &
                     ~((do_write && aw_idx_q == MIC_IRQ_STAT_IDX && wstrb_q[0]) ?
                       wdata_q[1:0] : 2'h0)) |
                    {fifo_underflow_evt, fifo_overflow_evt};
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Mode and clocking controls
  // ----------------------------------------------------------------
  // [RQ4] RGMII overrides
  // [RQ5] RMII or MII
  always_comb begin
    if (ctrl_q[MIC_B_RGMII]) begin
      mac_mode = MIC_MODE_RGMII;
    end else if (ctrl_q[MIC_B_RMII]) begin
      mac_mode = MIC_MODE_RMII;
    end else begin
      mac_mode = MIC_MODE_MII;
    end
  end

  // Delay enables drive an analog delay line of MIC_CLK_SHIFT_PS; too fine to count here
  // [RQ1] receive clock delay
  assign rx_clk_delay_en   = ctrl_q[MIC_B_RX_SHIFT];
  // [RQ2] inverted transmit delay
  assign tx_clk_delay_en   = !ctrl_q[MIC_B_TX_SHIFT_N];
  // [RQ3] shared clock hint
  assign tx_clk_synced     = ctrl_q[MIC_B_TX_SYNC];
  // [RQ6] RMII transmit shift
  assign rmii_tx_shift_en  = ctrl_q[MIC_B_RMII_SHIFT];
  // [RQ7] reference select
  assign ref_clk_50m_sel   = ctrl_q[MIC_B_REF_SEL];
  // [RQ8] FIFO bypass, 50 MHz out
  assign rx_fifo_bypass    = (mac_mode == MIC_MODE_RMII) && rmii_recovered_mode &&
                             !ctrl_q[MIC_B_FIFO_NORM];
  assign rx_clk_50m_out_en = rx_fifo_bypass;
  // [RQ13] tolerance decode
  // [RQ14] sizes the drift window
  assign eb_tolerance_bits = eb_tol(ctrl_q[MIC_B_EB_LSB +: 2]);

  // ----------------------------------------------------------------
  // CRS_DV generation
  // ----------------------------------------------------------------
  assign link_edge = lclk_q[1] && !lclk_q[2];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      crs_dv_q <= 1'b0;
    end else if (carrier_sense) begin
      crs_dv_q <= 1'b1;
    end else if (!rx_data_pending) begin
      crs_dv_q <= 1'b0;
    end else if (ctrl_q[MIC_B_REV10]) begin
      // [RQ9] hold until last data
      crs_dv_q <= 1'b1;
    end else if (link_edge) begin
      // [RQ10] toggle at packet end
      crs_dv_q <= !crs_dv_q;
    end
  end

  assign crs_dv = crs_dv_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence tail_edge_s;
    !carrier_sense && rx_data_pending && link_edge && !ctrl_q[MIC_B_REV10];
  endsequence

  sequence ctrl_read_s;
    ctrl_read && !fifo_overflow_evt && !fifo_underflow_evt;
  endsequence

  AST_RX_SHIFT: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ1]
    rx_clk_delay_en == ctrl_view[MIC_B_RX_SHIFT]) else $error("rx delay mismatch");
  AST_TX_SHIFT: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ2]
    tx_clk_delay_en != ctrl_view[MIC_B_TX_SHIFT_N]) else $error("tx delay sense wrong");
  AST_TX_SYNC: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ3]
    tx_clk_synced == ctrl_view[MIC_B_TX_SYNC]) else $error("tx sync mismatch");
  AST_MODE_RGMII: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ4]
    ctrl_view[MIC_B_RGMII] |-> mac_mode == MIC_MODE_RGMII) else $error("rgmii not taken");
  AST_MODE_RMII: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ5]
    !ctrl_view[MIC_B_RGMII] |-> (mac_mode == MIC_MODE_RMII) == ctrl_view[MIC_B_RMII])
    else $error("rmii/mii wrong");
  AST_RMII_SHIFT: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ6]
    rmii_tx_shift_en == ctrl_view[MIC_B_RMII_SHIFT]) else $error("rmii shift mismatch");
  AST_REF_SEL: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ7]
    ref_clk_50m_sel == ctrl_view[MIC_B_REF_SEL]) else $error("reference select mismatch");
  AST_BYPASS: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ8]
    rx_clk_50m_out_en |-> !ctrl_view[MIC_B_FIFO_NORM] && mac_mode == MIC_MODE_RMII)
    else $error("bypass without cause");
  AST_CRS_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ9]
    ctrl_q[MIC_B_REV10] && rx_data_pending ##1 ctrl_q[MIC_B_REV10] && rx_data_pending
    |=> crs_dv) else $error("crs_dv dropped early");
  AST_CRS_TOGGLE: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ10]
    tail_edge_s |=> crs_dv != $past(crs_dv)) else $error("crs_dv did not toggle");
  AST_OVF_COR: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ11]
    (fifo_overflow_evt |=> ovf_q) and (ctrl_read_s |=> !ovf_q)) else $error("overflow flag");
  AST_UNF_COR: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ12]
    (fifo_underflow_evt |=> unf_q) and (ctrl_read_s |=> !unf_q)) else $error("underflow flag");
  AST_EB_TOL: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ13]
    ctrl_q[1:0] == 2'h0 |-> eb_tolerance_bits == 4'he) else $error("tolerance decode");
  AST_RSVD: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RQ15]
    ctrl_read |=> s_axi_rdata[31:13] == 19'h00000) else $error("reserved bits set");

endmodule // mic_regs

// ==== hdl/mic_pkg.sv ====
// Constants, field layout and types for the MAC interface configuration register block
// What this block does
// [RQ1] Bit 12 set delays the receive clock 3.5 ns behind receive data, clear keeps them aligned.
// [RQ2] Bit 11 is inverted: zero enables the 3.5 ns transmit clock delay, one disables it.
// [RQ3] Bit 10 set declares a shared MAC/PHY clock so transmit latency may be cut.
// [RQ4] Bit 9 set selects RGMII mode, otherwise the mode follows bit 5; its reset comes from a strap.
// [RQ5] With RGMII off, bit 5 one selects RMII and zero selects MII.
// [RQ6] Bit 8 set turns on the RMII transmit-path clock shift, clear turns it off.
// [RQ7] Bit 7, strapped at reset, picks a 50 MHz CMOS reference (1) or 25 MHz crystal (0).
// [RQ8] In RMII recovered-clock mode bit 6 clear bypasses the receive FIFO and drives 50 MHz RX_CLK.
// [RQ9] Bit 4 set keeps CRS_DV high until the last data leaves, with no toggling at packet end.
// [RQ10] Bit 4 clear toggles CRS_DV at packet end once carrier sense has dropped.
// [RQ11] Bit 3 is set by a receive FIFO overflow and cleared when software reads the register.
// [RQ12] Bit 2 is set by a receive FIFO underflow and cleared when software reads the register.
// [RQ13] Bits 1:0 (reset 01) set the elasticity tolerance: 00=14, 01=2, 10=6, 11=10 bits.
// [RQ14] The elasticity buffer absorbs 50 MHz clock versus data drift; lengths halve at 100 ppm.
// [RQ15] Bits 15:13 are reserved, read as zero and ignore writes.
package mic_pkg;

  // ----------------------------------------------------------------
  // Register map (printed offsets are indices, byte address is 4x)
  // ----------------------------------------------------------------
  localparam logic [9:0]  MIC_CTRL_IDX     = 10'h017;
  localparam logic [9:0]  MIC_IRQ_STAT_IDX = 10'h020;
  localparam logic [9:0]  MIC_IRQ_MASK_IDX = 10'h021;

  // ----------------------------------------------------------------
  // Control/status field positions
  // ----------------------------------------------------------------
  localparam int          MIC_B_RX_SHIFT   = 12;
  localparam int          MIC_B_TX_SHIFT_N = 11;
  localparam int          MIC_B_TX_SYNC    = 10;
  localparam int          MIC_B_RGMII      = 9;
  localparam int          MIC_B_RMII_SHIFT = 8;
  localparam int          MIC_B_REF_SEL    = 7;
  localparam int          MIC_B_FIFO_NORM  = 6;
  localparam int          MIC_B_RMII       = 5;
  localparam int          MIC_B_REV10      = 4;
  localparam int          MIC_B_OVF        = 3;
  localparam int          MIC_B_UNF        = 2;
  localparam int          MIC_B_EB_LSB     = 0;
  localparam logic [15:0] MIC_CTRL_RST     = 16'h0041;
  localparam logic [15:0] MIC_CTRL_RW_MASK = 16'h1ff3;

  // Interrupt status bit positions
  localparam int          MIC_IRQ_OVF      = 0;
  localparam int          MIC_IRQ_UNF      = 1;

  // ----------------------------------------------------------------
  // Elasticity tolerance in bits per code, and clock shift time
  // ----------------------------------------------------------------
  localparam logic [3:0]  MIC_EB_TOL_00    = 4'he;
  localparam logic [3:0]  MIC_EB_TOL_01    = 4'h2;
  localparam logic [3:0]  MIC_EB_TOL_10    = 4'h6;
  localparam logic [3:0]  MIC_EB_TOL_11    = 4'ha;
  localparam int          MIC_CLK_SHIFT_PS = 3500;

  // Cycles after reset release before strap pins are trusted
  localparam logic [1:0]  MIC_STRAP_WAIT   = 2'h3;

  // AXI response codes
  localparam logic [1:0]  MIC_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  MIC_RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    MIC_MODE_MII,
    MIC_MODE_RMII,
    MIC_MODE_RGMII
  } mic_mode_e;

endpackage

// ==== verification/mic_mac_model.sv ====
// MAC-side partner model: carrier, pending data and link clock per frame
`timescale 1ns/1ns
module mic_mac_model (
  // Clock and frame request
  input  wire logic clk_sys,
  input  wire logic frame_go,
  // Link side
  output      logic link_clk,
  output      logic carrier_sense,
  output      logic rx_data_pending
);
  int   cnt = 0;
  logic run;

  // Carrier for 20 cycles, then data drains for 40 more
  always @(posedge clk_sys) begin
    if (frame_go && cnt == 0) begin
      cnt <= 1;
    end else if (cnt != 0) begin
      cnt <= (cnt == 70) ? 0 : cnt + 1;
    end
  end

  assign carrier_sense   = (cnt >= 1) && (cnt <= 20);
  assign rx_data_pending = (cnt >= 1) && (cnt <= 60);
  assign run             = (cnt != 0);

  // Link clock stands low between frames; odd offset keeps phase unrelated
  always begin
    link_clk = 1'b0;
    #37;
    forever begin
      #200;
      link_clk = run ? ~link_clk : 1'b0;
    end
  end
endmodule // mic_mac_model

// ==== verification/testbench.sv ====
// Self-checking bench for the MAC interface register block
`timescale 1ns/1ns
module testbench;
  import mic_pkg::*;
  localparam logic [11:0] A_CTRL = {MIC_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_STAT = {MIC_IRQ_STAT_IDX, 2'b00};
  localparam logic [11:0] A_MASK = {MIC_IRQ_MASK_IDX, 2'b00};
  logic clk_sys = 0, arst_n = 0, frame_go = 0, strap_rg = 1, strap_ref = 1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, recov = 0, ovf = 0, unf = 0;
  logic [1:0] bresp, rresp;
  logic link_clk, carrier_sense, rx_data_pending, crs_dv, irq;
  logic rx_dly, tx_dly, tx_sync, rmii_sh, ref50, byp, clk50;
  logic [3:0] eb;
  mic_mode_e mode;
  int err_total = 0, samples_checked = 0, cyc = 0, n0 = 0, n1 = 0;
  logic [3:0]  tol [4] = '{MIC_EB_TOL_00, MIC_EB_TOL_01, MIC_EB_TOL_10, MIC_EB_TOL_11};
  mic_mode_e   mtab [4] = '{MIC_MODE_MII, MIC_MODE_RMII, MIC_MODE_RGMII, MIC_MODE_RGMII};

  always #25 clk_sys = ~clk_sys;

  mic_regs i_mic_regs (.clk_sys(clk_sys), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rgmii_strap(strap_rg), .reference_frequency_strap(strap_ref), .link_clk(link_clk),
    .carrier_sense(carrier_sense), .rx_data_pending(rx_data_pending),
    .rmii_recovered_mode(recov), .fifo_overflow_evt(ovf), .fifo_underflow_evt(unf),
    .mac_mode(mode), .rx_clk_delay_en(rx_dly), .tx_clk_delay_en(tx_dly),
    .tx_clk_synced(tx_sync), .rmii_tx_shift_en(rmii_sh), .ref_clk_50m_sel(ref50),
    .rx_fifo_bypass(byp), .rx_clk_50m_out_en(clk50), .eb_tolerance_bits(eb),
    .crs_dv(crs_dv), .irq(irq));

  mic_mac_model i_mic_mac_model (.clk_sys(clk_sys), .frame_go(frame_go),
    .link_clk(link_clk), .carrier_sense(carrier_sense), .rx_data_pending(rx_data_pending));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d, checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run is well under 2000 cycles; cut any hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim;
    end
  end

  // Carrier gone but data still draining: tally crs_dv levels
  always @(posedge clk_sys) begin
    if (rx_data_pending && !carrier_sense) begin
      if (crs_dv) n1++;
      else n0++;
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 0;
    w  = 0;
    @(posedge clk_sys);
    awaddr <= a; awvalid <= 1; wdata <= d; wvalid <= 1; bready <= 1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      if (awvalid && awready) begin aw = 1; awvalid <= 0; end
      if (wvalid && wready) begin w = 1; wvalid <= 0; end
    end
    do @(posedge clk_sys); while (!bvalid);
    bready <= 0;
    chk({30'h0, bresp}, {30'h0, er});
    #1;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 0;
    do @(posedge clk_sys); while (!rvalid);
    rready <= 0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
    #1;
  endtask

  task automatic pulse(input int which);
    @(posedge clk_sys);
    if (which == 0) ovf <= 1; else unf <= 1;
    @(posedge clk_sys);
    ovf <= 0; unf <= 0;
    @(posedge clk_sys);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1;
    repeat (8) @(posedge clk_sys);
    rdc(A_CTRL, 32'h0000_02c1, MIC_RESP_OKAY);
    chk({30'h0, mode}, {30'h0, MIC_MODE_RGMII});
    chk({31'h0, ref50}, 32'h1);
    chk({31'h0, tx_dly}, 32'h1);
    chk({28'h0, eb}, {28'h0, MIC_EB_TOL_01});
    wr(A_CTRL, 32'h0000_ffff, MIC_RESP_OKAY);
    rdc(A_CTRL, 32'h0000_1ff3, MIC_RESP_OKAY);
    chk({28'h0, rx_dly, tx_dly, tx_sync, rmii_sh}, 32'hb);
    for (int i = 0; i < 4; i++) begin
      wr(A_CTRL, (i[1] << 9) | (i[0] << 5) | i, MIC_RESP_OKAY);
      chk({30'h0, mode}, {30'h0, mtab[i]});
      chk({28'h0, eb}, {28'h0, tol[i]});
      chk({29'h0, rx_dly, tx_sync, rmii_sh}, 32'h0);
    end
    recov <= 1;
    wr(A_CTRL, 32'h0000_0020, MIC_RESP_OKAY);
    chk({30'h0, byp, clk50}, 32'h3);
    wr(A_CTRL, 32'h0000_0060, MIC_RESP_OKAY);
    chk({30'h0, byp, clk50}, 32'h0);
    // sticky flags, clear on read, interrupt
    wr(A_MASK, 32'h3, MIC_RESP_OKAY);
    for (int e = 0; e < 2; e++) begin
      pulse(e);
      chk({31'h0, irq}, 32'h1);
      rdc(A_CTRL, 32'h0000_0060 | (32'h8 >> e), MIC_RESP_OKAY);
      rdc(A_CTRL, 32'h0000_0060, MIC_RESP_OKAY);
      rdc(A_STAT, 32'h1 << e, MIC_RESP_OKAY);
      wr(A_STAT, 32'h1 << e, MIC_RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
    end
    wr(A_MASK, 32'h0, MIC_RESP_OKAY);
    pulse(0);
    chk({31'h0, irq}, 32'h0);
    wr(A_STAT, 32'h3, MIC_RESP_OKAY);
    // Unmapped place
    rdc(12'hffc, 32'h0, MIC_RESP_SLVERR);
    wr(12'hffc, 32'h0000_1fff, MIC_RESP_SLVERR);
    // Overflow from the masked pulse is still flagged until the control read
    rdc(A_CTRL, 32'h0000_0068, MIC_RESP_OKAY);
    for (int r = 1; r >= 0; r--) begin
      wr(A_CTRL, 32'h0000_0060 | (r << 4), MIC_RESP_OKAY);
      n0 = 0;
      n1 = 0;
      @(posedge clk_sys) frame_go <= 1;
      @(posedge clk_sys) frame_go <= 0;
      repeat (80) @(posedge clk_sys);
      #1;
      if (r == 1) chk(n0, 0);
      else chk(n0 > 0 && n1 > 0, 1);
      chk({31'h0, crs_dv}, 32'h0);
    end
    // Second reset in mid-run with both straps low
    @(posedge clk_sys);
    strap_rg  <= 0;
    strap_ref <= 0;
    arst_n    <= 0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1;
    repeat (8) @(posedge clk_sys);
    rdc(A_CTRL, {16'h0000, MIC_CTRL_RST}, MIC_RESP_OKAY);
    chk({30'h0, mode}, {30'h0, MIC_MODE_MII});
    chk({31'h0, ref50}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    end_sim;
  end
endmodule // testbench
